/* File: design/crm_pkg.sv */
// crm_pkg: constants for the reset-mode and init control block
// assumes a 32-bit core datapath and a single core clock
package crm_pkg;

  // ****************************************
  // reset values and widths
  // ****************************************
  localparam int unsigned CRM_XLEN = 32;
  localparam logic [31:0] CRM_RESET_FETCH_ADDR = 32'h0FFF_FFF0;
  localparam logic [31:0] CRM_VEC_BASE_RST = 32'h0000_0000;
  localparam logic [15:0] CRM_VEC_LIMIT_RST = 16'h03FF;
  localparam logic [31:0] CRM_DESC_BASE_RST = 32'h0000_0000;
  localparam logic [15:0] CRM_DESC_LIMIT_RST = 16'hFFFF;
  localparam logic [31:0] CRM_REAL_ADDR_MASK = 32'h000F_FFFF;
  localparam logic [31:0] CRM_CR_RST = 32'h0000_0000;

  // ****************************************
  // control register bit positions
  // ****************************************
  localparam int unsigned CRM_CR0_PROTECT_BIT = 0;
  localparam int unsigned CRM_CR0_PAGING_BIT = 31;
  localparam int unsigned CRM_CR4_PSE_BIT = 4;
  localparam int unsigned CRM_CR4_STATE_SAVE_BIT = 9;
  localparam int unsigned CRM_CR4_SIMD_EXC_BIT = 10;

  // ****************************************
  // identification query
  // ****************************************
  localparam logic [31:0] CRM_ID_LEAF_FEATURES = 32'h0000_0001;
  localparam int unsigned CRM_FEAT_FLUSH_BIT = 19;
  localparam int unsigned CRM_FEAT_STATE_SAVE_BIT = 24;
  localparam int unsigned CRM_FEAT_SIMD1_BIT = 25;
  localparam int unsigned CRM_FEAT_SIMD2_BIT = 26;
  localparam int unsigned CRM_FEAT_PSE_BIT = 3;

  // ****************************************
  // operation codes
  // ****************************************
  typedef enum logic [2:0] {
    CRM_OP_NONE = 3'h0,
    CRM_OP_WR_CR0 = 3'h1,
    CRM_OP_WR_CR4 = 3'h2,
    CRM_OP_LOAD_VEC = 3'h3,
    CRM_OP_LOAD_DESC = 3'h4,
    CRM_OP_ID_QUERY = 3'h5
  } crm_op_t;

  // ****************************************
  // translation
  // ****************************************
  localparam int unsigned CRM_BIG_PAGE_SHIFT = 22;

endpackage : crm_pkg

/* File: design/crm_nmi_gate.sv */
// crm_nmi_gate: nonmaskable interrupt acceptance with nesting hold-off
// assumes the raw request is an asynchronous pin, active high after gating
`timescale 1ns/1ps
`default_nettype none
module crm_nmi_gate (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // request and service
  input wire logic nmi_pin_in,
  input wire logic nmi_done_in,
  output logic nmi_take_out,
  output logic nmi_busy_out
);
  import crm_pkg::*;

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic busy_r;
  logic busy_nxt;
  logic rise;

  // ****************************************
  // synchroniser and edge
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      sync1_r <= nmi_pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      busy_r <= busy_nxt;
    end
  end

  assign rise = sync2_r & ~prev_r;

  always_comb begin
    busy_nxt = busy_r;
    nmi_take_out = rise & ~busy_r;
    if (nmi_take_out) begin
      busy_nxt = 1'b1;
    end else if (nmi_done_in) begin
      busy_nxt = 1'b0;
    end
  end

  assign nmi_busy_out = busy_r;

  a_nmi_nest_block: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    busy_r |-> !nmi_take_out)
    else $error("nmi accepted while one in service");

endmodule : crm_nmi_gate
`default_nettype wire

/* File: design/crm_id_query.sv */
// crm_id_query: feature flag answer for the identification query
// assumes the leaf value arrives with a same-clock strobe
`timescale 1ns/1ps
`default_nettype none
module crm_id_query (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // query
  input wire logic query_in,
  input wire logic [31:0] leaf_in,
  output logic [31:0] data_out,
  output logic valid_out
);
  import crm_pkg::*;

  logic [31:0] data_r;
  logic [31:0] data_nxt;
  logic valid_r;
  logic valid_nxt;

  function automatic logic [31:0] feat_word();
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CRM_FEAT_PSE_BIT] = 1'b1;
    w[CRM_FEAT_FLUSH_BIT] = 1'b1;
    w[CRM_FEAT_STATE_SAVE_BIT] = 1'b1;
    w[CRM_FEAT_SIMD1_BIT] = 1'b1;
    w[CRM_FEAT_SIMD2_BIT] = 1'b1;
    return w;
  endfunction : feat_word

  always_comb begin
    valid_nxt = query_in;
    data_nxt = data_r;
    if (query_in) begin
      data_nxt = (leaf_in == CRM_ID_LEAF_FEATURES) ? feat_word() : 32'h0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_r <= 32'h0000_0000;
      valid_r <= 1'b0;
    end else begin
      data_r <= data_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign data_out = data_r;
  assign valid_out = valid_r;

  a_id_leaf_one: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    query_in && leaf_in == 32'h1 |=> valid_r && data_r[19] && data_r[26:24] == 3'h7)
    else $error("feature flags missing for leaf one");

endmodule : crm_id_query
`default_nettype wire

/* File: design/crm_top.sv */
// crm_top: reset mode, control registers, table bases, nmi, id query
// assumes an execution core issues one system operation per cycle
// Function
// - reset enters real mode, first fetch at FFFFFF0H
// - feature word: bit 25 simd, 26 simd2, 24 state save ops
// - query with accumulator one returns flags, bit 19 cache line flush
// - control four bit 9: os saves simd state
// - control four bit 10: os handles simd fp exceptions
// - vector table base resets to zero, replaced by load op
// - real mode addresses limited to one megabyte
// - nmi always accepted except while one in service
// - setting protect bit 0 of control zero enters protected mode
// - descriptor table base and limit loaded by load op
// - vector table base and limit loaded by load op
// - with 4 MByte pages only a directory translates
// - reset clears paging enable in control zero
`timescale 1ns/1ps
`default_nettype none
module crm_top (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // system operation port
  input wire crm_pkg::crm_op_t OP_IN,
  input wire logic [31:0] OP_DATA_IN,
  input wire logic [15:0] OP_LIMIT_IN,
  // identification answer
  output logic [31:0] ID_DATA_OUT,
  output logic ID_VALID_OUT,
  // control state
  output logic [31:0] CR0_OUT,
  output logic [31:0] CR4_OUT,
  output logic PROTECT_ENABLE_OUT,
  output logic PAGING_ENABLE_OUT,
  output logic OS_STATE_SAVE_SUPPORT_OUT,
  output logic OS_SIMD_EXC_SUPPORT_OUT,
  // table registers
  output logic [31:0] VEC_BASE_OUT,
  output logic [15:0] VEC_LIMIT_OUT,
  output logic [31:0] DESC_BASE_OUT,
  output logic [15:0] DESC_LIMIT_OUT,
  // fetch and translation
  output logic [31:0] FETCH_ADDR_OUT,
  input wire logic [31:0] LIN_ADDR_IN,
  input wire logic [31:0] DIR_ENTRY_IN,
  output logic [31:0] PHYS_ADDR_OUT,
  output logic BIG_PAGE_OUT,
  // nmi
  input wire logic NMI_IN,
  input wire logic NMI_DONE_IN,
  output logic NMI_TAKE_OUT,
  output logic NMI_BUSY_OUT
);
  import crm_pkg::*;

  logic [31:0] cr0_r;
  logic [31:0] cr0_nxt;
  logic [31:0] cr4_r;
  logic [31:0] cr4_nxt;
  logic [31:0] vec_base_r;
  logic [31:0] vec_base_nxt;
  logic [15:0] vec_lim_r;
  logic [15:0] vec_lim_nxt;
  logic [31:0] desc_base_r;
  logic [31:0] desc_base_nxt;
  logic [15:0] desc_lim_r;
  logic [15:0] desc_lim_nxt;
  logic [31:0] phys_r;
  logic [31:0] phys_nxt;
  logic big_r;
  logic big_nxt;

  // ****************************************
  // control registers
  // ****************************************
  // paging only legal together with protection
  function automatic logic [31:0] cr0_fix(input logic [31:0] v);
    logic [31:0] w;
    w = v;
    if (!v[CRM_CR0_PROTECT_BIT]) begin
      w[CRM_CR0_PAGING_BIT] = 1'b0;
    end
    return w;
  endfunction : cr0_fix

  always_comb begin
    cr0_nxt = cr0_r;
    cr4_nxt = cr4_r;
    vec_base_nxt = vec_base_r;
    vec_lim_nxt = vec_lim_r;
    desc_base_nxt = desc_base_r;
    desc_lim_nxt = desc_lim_r;
    case (OP_IN)
      CRM_OP_WR_CR0: begin
        cr0_nxt = cr0_fix(OP_DATA_IN);
      end
      CRM_OP_WR_CR4: begin
        cr4_nxt = OP_DATA_IN;
      end
      CRM_OP_LOAD_VEC: begin
        vec_base_nxt = OP_DATA_IN;
        vec_lim_nxt = OP_LIMIT_IN;
      end
      CRM_OP_LOAD_DESC: begin
        desc_base_nxt = OP_DATA_IN;
        desc_lim_nxt = OP_LIMIT_IN;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cr0_r <= CRM_CR_RST;
      cr4_r <= CRM_CR_RST;
      vec_base_r <= CRM_VEC_BASE_RST;
      vec_lim_r <= CRM_VEC_LIMIT_RST;
      desc_base_r <= CRM_DESC_BASE_RST;
      desc_lim_r <= CRM_DESC_LIMIT_RST;
    end else begin
      cr0_r <= cr0_nxt;
      cr4_r <= cr4_nxt;
      vec_base_r <= vec_base_nxt;
      vec_lim_r <= vec_lim_nxt;
      desc_base_r <= desc_base_nxt;
      desc_lim_r <= desc_lim_nxt;
    end
  end

  // ****************************************
  // address translation
  // ****************************************
  always_comb begin
    phys_nxt = LIN_ADDR_IN;
    big_nxt = 1'b0;
    if (!cr0_r[CRM_CR0_PROTECT_BIT]) begin
      phys_nxt = LIN_ADDR_IN & CRM_REAL_ADDR_MASK;
    end else if (cr0_r[CRM_CR0_PAGING_BIT] && cr4_r[CRM_CR4_PSE_BIT]) begin
      big_nxt = 1'b1;
      phys_nxt = {DIR_ENTRY_IN[31:CRM_BIG_PAGE_SHIFT],
                  LIN_ADDR_IN[CRM_BIG_PAGE_SHIFT-1:0]};
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      phys_r <= 32'h0000_0000;
      big_r <= 1'b0;
    end else begin
      phys_r <= phys_nxt;
      big_r <= big_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign CR0_OUT = cr0_r;
  assign CR4_OUT = cr4_r;
  assign PROTECT_ENABLE_OUT = cr0_r[CRM_CR0_PROTECT_BIT];
  assign PAGING_ENABLE_OUT = cr0_r[CRM_CR0_PAGING_BIT];
  assign OS_STATE_SAVE_SUPPORT_OUT = cr4_r[CRM_CR4_STATE_SAVE_BIT];
  assign OS_SIMD_EXC_SUPPORT_OUT = cr4_r[CRM_CR4_SIMD_EXC_BIT];
  assign VEC_BASE_OUT = vec_base_r;
  assign VEC_LIMIT_OUT = vec_lim_r;
  assign DESC_BASE_OUT = desc_base_r;
  assign DESC_LIMIT_OUT = desc_lim_r;
  assign FETCH_ADDR_OUT = CRM_RESET_FETCH_ADDR;
  assign PHYS_ADDR_OUT = phys_r;
  assign BIG_PAGE_OUT = big_r;

  // ****************************************
  // submodules
  // ****************************************
  // external gate is board side; pin taken as given
  crm_nmi_gate u_nmi (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .nmi_pin_in(NMI_IN),
    .nmi_done_in(NMI_DONE_IN),
    .nmi_take_out(NMI_TAKE_OUT),
    .nmi_busy_out(NMI_BUSY_OUT)
  );

  crm_id_query u_id (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .query_in(OP_IN == CRM_OP_ID_QUERY),
    .leaf_in(OP_DATA_IN),
    .data_out(ID_DATA_OUT),
    .valid_out(ID_VALID_OUT)
  );

  // ****************************************
  // checks
  // ****************************************
  a_reset_real_mode: assert property (
    @(posedge REF_CLK_IN) $rose(RST_N_IN) |-> !cr0_r[0] && !cr0_r[31])
    else $error("not in real mode after reset");

  a_protect_entry: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    OP_IN == CRM_OP_WR_CR0 && OP_DATA_IN[0] |=> PROTECT_ENABLE_OUT)
    else $error("protect bit write did not enter protected mode");

  a_state_save_flag: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    OP_IN == CRM_OP_WR_CR4 |=>
      OS_STATE_SAVE_SUPPORT_OUT == $past(OP_DATA_IN[9]))
    else $error("state save flag not taken from bit 9");

  a_simd_exc_flag: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    OP_IN == CRM_OP_WR_CR4 |=>
      OS_SIMD_EXC_SUPPORT_OUT == $past(OP_DATA_IN[10]))
    else $error("simd exception flag not taken from bit 10");

  a_vec_load: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    OP_IN == CRM_OP_LOAD_VEC |=> VEC_BASE_OUT == $past(OP_DATA_IN) &&
      VEC_LIMIT_OUT == $past(OP_LIMIT_IN))
    else $error("vector table load lost");

  a_desc_load: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    OP_IN == CRM_OP_LOAD_DESC |=> DESC_BASE_OUT == $past(OP_DATA_IN) &&
      DESC_LIMIT_OUT == $past(OP_LIMIT_IN))
    else $error("descriptor table load lost");

  a_vec_reset_zero: assert property (
    @(posedge REF_CLK_IN) $rose(RST_N_IN) |-> VEC_BASE_OUT == 32'h0)
    else $error("vector base not zero after reset");

  a_os_flags_reset: assert property (
    @(posedge REF_CLK_IN) $rose(RST_N_IN) |->
      !OS_STATE_SAVE_SUPPORT_OUT && !OS_SIMD_EXC_SUPPORT_OUT)
    else $error("os support flags set after reset");

  a_real_window: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !PROTECT_ENABLE_OUT ##1 !PROTECT_ENABLE_OUT |-> PHYS_ADDR_OUT[31:20] == 12'h0)
    else $error("real mode address beyond one megabyte");

  // ****************************************
  // further checks
  // ****************************************
  // paging never without protection
  a_paging_needs_pe: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    PAGING_ENABLE_OUT |-> PROTECT_ENABLE_OUT)
    else $error("paging on while protection off");

  a_paging_reset_off: assert property (
    @(posedge REF_CLK_IN) $rose(RST_N_IN) |-> !PAGING_ENABLE_OUT)
    else $error("paging on after reset");

  a_big_page_flag: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    PROTECT_ENABLE_OUT && PAGING_ENABLE_OUT && CR4_OUT[4] |=> BIG_PAGE_OUT)
    else $error("big page translation not flagged");

  a_big_page_addr: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    PROTECT_ENABLE_OUT && PAGING_ENABLE_OUT && CR4_OUT[4] |=>
      PHYS_ADDR_OUT[31:22] == $past(DIR_ENTRY_IN[31:22]) &&
      PHYS_ADDR_OUT[21:0] == $past(LIN_ADDR_IN[21:0]))
    else $error("big page address wrong");

  a_nmi_take_busy: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    NMI_TAKE_OUT |=> NMI_BUSY_OUT)
    else $error("nmi taken but not in service");

  a_vec_limit_reset: assert property (
    @(posedge REF_CLK_IN) $rose(RST_N_IN) |-> VEC_LIMIT_OUT == 16'h03FF)
    else $error("vector limit not at default after reset");

  a_desc_reset: assert property (
    @(posedge REF_CLK_IN) $rose(RST_N_IN) |->
      DESC_BASE_OUT == 32'h0 && DESC_LIMIT_OUT == 16'hFFFF)
    else $error("descriptor table not at default after reset");

  a_id_valid_pulse: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    OP_IN == CRM_OP_ID_QUERY |=> ID_VALID_OUT)
    else $error("query not answered");

  a_id_valid_idle: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    OP_IN != CRM_OP_ID_QUERY |=> !ID_VALID_OUT)
    else $error("answer without query");

endmodule : crm_top
`default_nettype wire

/* File: dv/crm_nmi_board.sv */
// crm_nmi_board: board-side nmi gate with a software port flag
// assumes the same core clock and reset as the block under test
`timescale 1ns/1ps
`default_nettype none
module crm_nmi_board (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // port flag and raw request
  input wire logic flag_wr_in,
  input wire logic flag_val_in,
  input wire logic raw_nmi_in,
  output logic nmi_out
);
  logic flag_r;
  logic flag_nxt;

  always_comb begin
    flag_nxt = flag_wr_in ? flag_val_in : flag_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign nmi_out = raw_nmi_in & flag_r;
endmodule : crm_nmi_board
`default_nettype wire

/* File: dv/crm_top_test.sv */
// crm_top_test: directed scenarios for reset mode and init control
// assumes crm_pkg, crm_top and crm_nmi_board are compiled first
`timescale 1ns/1ps
`default_nettype none
module crm_top_test;
  import crm_pkg::*;
  logic clk, rst_n, raw_nmi, flag_wr, flag_val, nmi_pin, done;
  crm_op_t op;
  logic [31:0] od, lin, dir, id_d, cr0, cr4, vb, db, fa, pa;
  logic [15:0] ol, vl, dl;
  logic id_v, pe, pg, oss, ose, bp, take, busy, seen;
  int fails, checks;

  crm_top dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .OP_IN(op),
    .OP_DATA_IN(od), .OP_LIMIT_IN(ol), .ID_DATA_OUT(id_d),
    .ID_VALID_OUT(id_v), .CR0_OUT(cr0), .CR4_OUT(cr4),
    .PROTECT_ENABLE_OUT(pe), .PAGING_ENABLE_OUT(pg),
    .OS_STATE_SAVE_SUPPORT_OUT(oss), .OS_SIMD_EXC_SUPPORT_OUT(ose),
    .VEC_BASE_OUT(vb), .VEC_LIMIT_OUT(vl), .DESC_BASE_OUT(db),
    .DESC_LIMIT_OUT(dl), .FETCH_ADDR_OUT(fa), .LIN_ADDR_IN(lin),
    .DIR_ENTRY_IN(dir), .PHYS_ADDR_OUT(pa), .BIG_PAGE_OUT(bp),
    .NMI_IN(nmi_pin), .NMI_DONE_IN(done), .NMI_TAKE_OUT(take),
    .NMI_BUSY_OUT(busy));

  crm_nmi_board board (.clk_in(clk), .rst_n_in(rst_n),
    .flag_wr_in(flag_wr), .flag_val_in(flag_val),
    .raw_nmi_in(raw_nmi), .nmi_out(nmi_pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic issue(input crm_op_t o, input logic [31:0] d,
                       input logic [15:0] l);
    @(posedge clk);
    op <= o;
    od <= d;
    ol <= l;
    @(posedge clk);
    op <= CRM_OP_NONE;
    #1;
  endtask : issue

  // a missed take when one is due cuts the run short
  task automatic wait_take(input logic must);
    seen = 1'b0;
    for (int i = 0; i < 8 && !(must && seen); i++) begin
      @(posedge clk);
      #1;
      if (take === 1'b1) seen = 1'b1;
    end
    if (must && !seen) begin
      fails++;
      $display("mismatch at %0t: nmi never taken", $time);
      stop_test();
    end
  endtask : wait_take

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
  endtask : do_reset

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk(fa, CRM_RESET_FETCH_ADDR);
    chk({31'h0, pe}, 32'h0);
    chk({31'h0, pg}, 32'h0);
    chk(cr0, 32'h0);
    chk({30'h0, oss, ose}, 32'h0);
    chk(cr4, 32'h0);
    chk(vb, 32'h0);
    chk({16'h0, vl}, 32'h03FF);
    chk(db, 32'h0);
    chk({16'h0, dl}, 32'hFFFF);
    chk({31'h0, busy}, 32'h0);
  endtask : t_reset

  task automatic t_ctrl;
    // paging alone is refused while protection is off
    issue(CRM_OP_WR_CR0, 32'h8000_0000, 16'h0);
    chk({31'h0, pg}, 32'h0);
    issue(CRM_OP_WR_CR0, 32'h0000_0001, 16'h0);
    chk({30'h0, pe, pg}, 32'h2);
    chk(cr0, 32'h0000_0001);
    issue(CRM_OP_WR_CR4, 32'h0000_0600, 16'h0);
    chk({30'h0, oss, ose}, 32'h3);
    issue(CRM_OP_WR_CR4, 32'h0000_0400, 16'h0);
    chk({30'h0, oss, ose}, 32'h1);
    issue(CRM_OP_WR_CR4, 32'h0000_0200, 16'h0);
    chk({30'h0, oss, ose}, 32'h2);
    chk(cr4, 32'h0000_0200);
  endtask : t_ctrl

  task automatic t_id;
    issue(CRM_OP_ID_QUERY, 32'h1, 16'h0);
    chk({31'h0, id_v}, 32'h1);
    chk(id_d, 32'h0708_0008);
    @(posedge clk);
    #1;
    chk({31'h0, id_v}, 32'h0);
    issue(CRM_OP_ID_QUERY, 32'h2, 16'h0);
    chk(id_d, 32'h0);
  endtask : t_id

  // software side: table loads stand for descriptor setup
  task automatic t_tables;
    // back to back loads, both must land
    @(posedge clk);
    op <= CRM_OP_LOAD_VEC;
    od <= 32'h0001_2000;
    ol <= 16'h07FF;
    @(posedge clk);
    op <= CRM_OP_LOAD_DESC;
    od <= 32'h0003_4000;
    ol <= 16'h0027;
    @(posedge clk);
    op <= CRM_OP_NONE;
    #1;
    chk(vb, 32'h0001_2000);
    chk({16'h0, vl}, 32'h07FF);
    chk(db, 32'h0003_4000);
    chk({16'h0, dl}, 32'h0027);
  endtask : t_tables

  task automatic t_xlate;
    @(posedge clk);
    lin <= 32'h1234_5678;
    dir <= 32'hABC0_0000;
    @(posedge clk);
    @(posedge clk);
    #1;
    chk(pa, 32'h0004_5678);
    issue(CRM_OP_WR_CR4, 32'h0000_0010, 16'h0);
    issue(CRM_OP_WR_CR0, 32'h8000_0001, 16'h0);
    @(posedge clk);
    #1;
    chk(pa, 32'hABF4_5678);
    chk({31'h0, bp}, 32'h1);
  endtask : t_xlate

  task automatic t_nmi;
    @(posedge clk);
    raw_nmi <= 1'b1;
    wait_take(1'b0);
    chk({31'h0, seen}, 32'h0);
    @(posedge clk);
    raw_nmi <= 1'b0;
    flag_wr <= 1'b1;
    flag_val <= 1'b1;
    @(posedge clk);
    flag_wr <= 1'b0;
    repeat (3) @(posedge clk);
    raw_nmi <= 1'b1;
    wait_take(1'b1);
    @(posedge clk);
    #1;
    chk({31'h0, busy}, 32'h1);
    @(posedge clk);
    raw_nmi <= 1'b0;
    repeat (4) @(posedge clk);
    raw_nmi <= 1'b1;
    // nested request while in service is dropped
    wait_take(1'b0);
    chk({31'h0, seen}, 32'h0);
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    raw_nmi <= 1'b0;
    @(posedge clk);
    #1;
    chk({31'h0, busy}, 32'h0);
  endtask : t_nmi

  initial begin
    rst_n = 1'b0;
    op = CRM_OP_NONE;
    od = 32'h0;
    ol = 16'h0;
    lin = 32'h0;
    dir = 32'h0;
    raw_nmi = 1'b0;
    flag_wr = 1'b0;
    flag_val = 1'b0;
    done = 1'b0;
    fails = 0;
    checks = 0;
    do_reset();
    t_reset();
    t_ctrl();
    t_id();
    t_tables();
    // second reset mid-run must restore every default that t_reset checks
    do_reset();
    t_reset();
    t_xlate();
    do_reset();
    t_nmi();
    stop_test();
  end
endmodule : crm_top_test
`default_nettype wire
